// [logic/vmes_params.svh]
// Purpose: constants of the bus slave: address modifier codes, decode windows, sizes
// Assumes: included by the slave and the synchroniser
// Notes: definitions only
`ifndef VMES_PARAMS_SVH
`define VMES_PARAMS_SVH
`define VMES_AM_A24_SUP_BLT 6'h3F
`define VMES_AM_A24_SUP_PRG 6'h3E
`define VMES_AM_A24_SUP_DAT 6'h3D
`define VMES_AM_A24_USR_BLT 6'h3B
`define VMES_AM_A24_USR_PRG 6'h3A
`define VMES_AM_A24_USR_DAT 6'h39
`define VMES_AM_A16_SUP 6'h2D
`define VMES_AM_A16_USR 6'h29
`define VMES_AM_A32_SUP_BLT 6'h0F
`define VMES_AM_A32_SUP_PRG 6'h0E
`define VMES_AM_A32_SUP_DAT 6'h0D
`define VMES_AM_A32_USR_BLT 6'h0B
`define VMES_AM_A32_USR_PRG 6'h0A
`define VMES_AM_A32_USR_DAT 6'h09
`define VMES_A16_BASE 16'h0000
`define VMES_A16_MASK 16'hF000
`define VMES_A24_BASE 24'h000000
`define VMES_A24_MASK 24'hF00000
`define VMES_A32_BASE 32'h00000000
`define VMES_A32_MASK 32'hFF000000
`define VMES_BLT_SPAN_BITS 8
`define VMES_BUF_DEPTH 2
`define VMES_SYNC_DEPTH_MIN 1
`endif

// [logic/vmes_pkg.sv]
// Purpose: types of the bus slave
// Assumes: nothing
// Notes: big-endian lanes, be[k] is byte k of the aligned word
`default_nettype none
package vmes_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_SEL = 3'h1, S_PUSH = 3'h2, S_WAIT = 3'h3,
    S_DRIVE = 3'h4, S_ACK = 3'h5, S_ERR = 3'h6, S_MISS = 3'h7
  } vmes_state_t;
  typedef enum logic [1:0] {SP_A16 = 2'h0, SP_A24 = 2'h1, SP_A32 = 2'h2, SP_NONE = 2'h3}
    vmes_space_t;
  typedef struct packed {
    logic [31:0] addr; logic [5:0] am; logic as_n; logic ds0_n; logic ds1_n;
    logic write_n; logic lword_n; logic [31:0] data;
  } vmes_bus_in_t;
  typedef struct packed {
    logic [31:0] data; logic data_oe; logic dtack_n; logic dtack_oe; logic berr_n; logic berr_oe;
  } vmes_bus_out_t;
  typedef struct packed {
    logic write; logic [5:0] am; logic [31:0] addr; logic [3:0] be; logic [31:0] data;
  } vmes_req_t;
  typedef struct packed {logic valid; logic err; logic [31:0] data;} vmes_rsp_t;
  typedef struct packed {
    vmes_state_t st; logic [31:0] addr; logic [5:0] am; logic wr; logic lword_n;
    logic [3:0] be; logic [31:0] wdata; logic blt; logic over; logic [1:0] dsp;
    vmes_bus_out_t bout;
  } vmes_slv_t;
endpackage : vmes_pkg
`default_nettype wire

// [logic/vmes_sync.sv]
// Purpose: three-stage synchroniser for asynchronous bus strobes
// Assumes: d changes at any time
// Notes: q moves only when stages two and three agree
`default_nettype none
`include "vmes_params.svh"
module vmes_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST = '1
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {logic [W-1:0] s1; logic [W-1:0] s2; logic [W-1:0] s3; logic [W-1:0] q;}
    vmes_sync_st_t;
  vmes_sync_st_t st_reg;
  vmes_sync_st_t st_next;
  logic [W-1:0] agree;
  if (W < `VMES_SYNC_DEPTH_MIN) begin : g_bad
    $error("vmes_sync: width must be positive");
  end
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign agree[i] = st_reg.s2[i] == st_reg.s3[i];
  end
  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.q = (agree & st_reg.s3) | (~agree & st_reg.q);
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_reg <= {RST, RST, RST, RST};
    else
      st_reg <= st_next;
  end
  assign q = st_reg.q;
endmodule : vmes_sync
`default_nettype wire

// [logic/vmes_buf.sv]
// Purpose: shift buffer with valid and ready on both sides
// Assumes: DEPTH of two or more
// Notes: head and ready come from flops; a full buffer refuses a push
`default_nettype none
module vmes_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  typedef struct packed {logic [DEPTH-1:0][W-1:0] ent; logic [DEPTH-1:0] vld;} vmes_buf_st_t;
  vmes_buf_st_t st_reg;
  vmes_buf_st_t st_next;
  if (DEPTH < 2) begin : g_bad
    $error("vmes_buf: depth below two");
  end
  always_comb
  begin
    logic placed;
    placed = 1'b0;
    st_next = st_reg;
    if (st_reg.vld[0] && out_ready)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        st_next.ent[i] = st_reg.ent[i + 1];
        st_next.vld[i] = st_reg.vld[i + 1];
      end
      st_next.vld[DEPTH-1] = 1'b0;
    end
    if (in_valid && !st_reg.vld[DEPTH-1])
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        if (!st_next.vld[i] && !placed)
        begin
          st_next.ent[i] = in_data;
          st_next.vld[i] = 1'b1;
          placed = 1'b1;
        end
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
  assign in_ready = !st_reg.vld[DEPTH-1];
  assign out_valid = st_reg.vld[0];
  assign out_data = st_reg.ent[0];
endmodule : vmes_buf
`default_nettype wire

// [logic/vmes_slave.sv]
// Purpose: slave end of the asynchronous backplane data transfer bus
// Assumes: strobes arrive asynchronously; address and data settle before their strobes
// Notes:
// Operation
// - separate address and data lines, full strobe set
// - decode extended, standard and short address spaces
// - six modifier lines decide whether slave responds
// - 24-bit privileged modifiers 3F, 3E, 3D
// - 24-bit unprivileged modifiers 3B, 3A, 39
// - 16-bit modifiers 2D privileged, 29 unprivileged
// - 32-bit privileged modifiers 0F, 0E, 0D
// - 32-bit unprivileged modifiers 0B, 0A, 09
// - byte, word and long transfers everywhere
// - read, write, address-only, read-modify-write, unaligned
// - size mismatch or error answers bus error
// - strobes, address bit one, long word select lanes
// - slave latches write data, then acknowledges
// - acknowledge released only after strobes released
// - read: slave drives data on data strobes
// - read acknowledge only with stable data
// - unaligned patterns 1-2, 0-2, 1-3 supported
// - block addresses ascend, at most 256 bytes
`default_nettype none
`include "vmes_params.svh"
module vmes_slave
  import vmes_pkg::*;
#(
  parameter logic [15:0] A16_BASE = `VMES_A16_BASE,
  parameter logic [15:0] A16_MASK = `VMES_A16_MASK,
  parameter logic [23:0] A24_BASE = `VMES_A24_BASE,
  parameter logic [23:0] A24_MASK = `VMES_A24_MASK,
  parameter logic [31:0] A32_BASE = `VMES_A32_BASE,
  parameter logic [31:0] A32_MASK = `VMES_A32_MASK,
  parameter bit A32_EN = 1'b1,
  parameter bit D32_EN = 1'b1,
  parameter int BUF_DEPTH = `VMES_BUF_DEPTH
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire vmes_bus_in_t bus_in,
  output vmes_bus_out_t bus_out,
  input wire logic priv_only,
  output vmes_req_t req,
  output logic req_valid,
  input wire logic req_ready,
  input wire vmes_rsp_t rsp
);
  if (BUF_DEPTH < 2) begin : g_bad
    $error("vmes_slave: buffer depth below two");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // lane helpers

  // returns {bad, be}; be[k] is byte k, ds = {ds1, ds0}
  function automatic logic [4:0] vmes_lanes(input logic [1:0] ds, input logic a1,
                                            input logic ln);
    logic [4:0] r;
    r = 5'h10;
    if (ln)
      r = a1 ? {1'h0, ds[0], ds[1], 2'h0} : {3'h0, ds[0], ds[1]};
    else if (!a1)
      r = (ds == 2'h3) ? 5'h0F : (ds[1] ? 5'h07 : 5'h0E);
    else if (ds == 2'h3)
      r = 5'h06;
    return r;
  endfunction : vmes_lanes

  // short transfers use the low sixteen data lines
  function automatic logic [31:0] vmes_to_word(input logic [31:0] d, input logic ln,
                                               input logic a1);
    if (!ln)
      return d;
    return a1 ? {16'h0000, d[15:0]} : {d[15:0], 16'h0000};
  endfunction : vmes_to_word

  function automatic logic [31:0] vmes_to_bus(input logic [31:0] w, input logic ln,
                                              input logic a1);
    if (!ln)
      return w;
    return a1 ? {16'h0000, w[15:0]} : {16'h0000, w[31:16]};
  endfunction : vmes_to_bus

  ////////////////////////////////////////////////////////////////////////////////
  // strobe synchroniser

  logic [2:0] strb_q;
  logic as_s;
  logic [1:0] ds;

  vmes_sync #(
    .W(3),
    .RST(3'h7)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d({bus_in.as_n, bus_in.ds1_n, bus_in.ds0_n}),
    .q(strb_q)
  );

  assign as_s = !strb_q[2];
  assign ds = ~strb_q[1:0];

  ////////////////////////////////////////////////////////////////////////////////
  // modifier and address decode

  logic [3:0] am_dec;
  vmes_space_t sp;
  logic am_blt;
  logic am_priv;
  logic hit;

  always_comb
  begin
    case (bus_in.am)
      `VMES_AM_A24_SUP_BLT: am_dec = {SP_A24, 2'h3};
      `VMES_AM_A24_SUP_PRG: am_dec = {SP_A24, 2'h1};
      `VMES_AM_A24_SUP_DAT: am_dec = {SP_A24, 2'h1};
      `VMES_AM_A24_USR_BLT: am_dec = {SP_A24, 2'h2};
      `VMES_AM_A24_USR_PRG: am_dec = {SP_A24, 2'h0};
      `VMES_AM_A24_USR_DAT: am_dec = {SP_A24, 2'h0};
      `VMES_AM_A16_SUP: am_dec = {SP_A16, 2'h1};
      `VMES_AM_A16_USR: am_dec = {SP_A16, 2'h0};
      `VMES_AM_A32_SUP_BLT: am_dec = {SP_A32, 2'h3};
      `VMES_AM_A32_SUP_PRG: am_dec = {SP_A32, 2'h1};
      `VMES_AM_A32_SUP_DAT: am_dec = {SP_A32, 2'h1};
      `VMES_AM_A32_USR_BLT: am_dec = {SP_A32, 2'h2};
      `VMES_AM_A32_USR_PRG: am_dec = {SP_A32, 2'h0};
      `VMES_AM_A32_USR_DAT: am_dec = {SP_A32, 2'h0};
      default: am_dec = {SP_NONE, 2'h0};
    endcase
  end

  assign sp = vmes_space_t'(am_dec[3:2]);
  assign am_blt = am_dec[1];
  assign am_priv = am_dec[0];

  always_comb
  begin
    unique case (sp)
      SP_A16: hit = (bus_in.addr[15:0] & A16_MASK) == (A16_BASE & A16_MASK);
      SP_A24: hit = (bus_in.addr[23:0] & A24_MASK) == (A24_BASE & A24_MASK);
      SP_A32: hit = A32_EN && ((bus_in.addr & A32_MASK) == (A32_BASE & A32_MASK));
      SP_NONE: hit = 1'b0;
    endcase
    if (priv_only && !am_priv)
      hit = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // cycle state machine

  vmes_slv_t st;
  vmes_slv_t nx;
  logic [4:0] lane;
  logic lane_bad;
  logic ds_ok;
  logic buf_in_valid;
  logic buf_in_ready;
  logic [2:0] nbytes;
  vmes_req_t push;

  assign lane = vmes_lanes(ds, st.addr[1], bus_in.lword_n);
  assign lane_bad = lane[4] || st.over || (!bus_in.lword_n && !D32_EN);
  // a beat counts only once the synced strobes held one nonzero value for two edges
  assign ds_ok = (ds != 2'h0) && (ds == st.dsp);
  assign nbytes = 3'($countones(st.be));
  assign buf_in_valid = st.st == S_PUSH;
  assign push = '{write: st.wr, am: st.am, addr: {st.addr[31:2], 2'h0}, be: st.be,
                  data: st.wdata};

  always_comb
  begin
    nx = st;
    nx.dsp = ds;
    unique case (st.st)
      S_IDLE:
        if (as_s)
        begin
          nx.addr = bus_in.addr;
          nx.am = bus_in.am;
          nx.blt = am_blt;
          nx.over = 1'b0;
          nx.st = hit ? S_SEL : S_MISS;
        end
      S_MISS:
        if (!as_s)
          nx.st = S_IDLE;
      S_SEL:
        if (!as_s)
          nx.st = S_IDLE;
        else if (ds_ok)
        begin
          nx.wr = !bus_in.write_n;
          nx.lword_n = bus_in.lword_n;
          nx.be = lane[3:0];
          nx.wdata = vmes_to_word(bus_in.data, bus_in.lword_n, st.addr[1]);
          if (lane_bad)
          begin
            nx.bout.berr_oe = 1'b1;
            nx.st = S_ERR;
          end
          else
            nx.st = S_PUSH;
        end
      S_PUSH:
        if (buf_in_ready)
        begin
          if (st.wr)
          begin
            nx.bout.dtack_oe = 1'b1;
            nx.st = S_ACK;
          end
          else
            nx.st = S_WAIT;
        end
      S_WAIT:
        if (rsp.valid)
        begin
          if (rsp.err)
          begin
            nx.bout.berr_oe = 1'b1;
            nx.st = S_ERR;
          end
          else
          begin
            nx.bout.data = vmes_to_bus(rsp.data, st.lword_n, st.addr[1]);
            nx.bout.data_oe = 1'b1;
            nx.st = S_DRIVE;
          end
        end
      S_DRIVE:
      begin
        nx.bout.dtack_oe = 1'b1;
        nx.st = S_ACK;
      end
      // release on the strobes alone, so a held address strobe chains the next beat
      S_ACK, S_ERR:
        if (ds == 2'h0)
        begin
          nx.bout.dtack_oe = 1'b0;
          nx.bout.berr_oe = 1'b0;
          nx.bout.data_oe = 1'b0;
          nx.st = as_s ? S_SEL : S_IDLE;
          if (st.blt && st.st == S_ACK)
          begin
            nx.addr = st.addr + {29'h0, nbytes};
            nx.over = nx.addr[31:`VMES_BLT_SPAN_BITS] != st.addr[31:`VMES_BLT_SPAN_BITS];
          end
        end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.st <= S_IDLE;
    end
    else
      st <= nx;
  end

  assign bus_out = st.bout;

  ////////////////////////////////////////////////////////////////////////////////
  // request buffer to the local side

  vmes_buf #(
    .W($bits(vmes_req_t)),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(buf_in_valid),
    .in_data(push),
    .in_ready(buf_in_ready),
    .out_valid(req_valid),
    .out_data(req),
    .out_ready(req_ready)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  chk_ack_berr_excl: assert property (!(st.bout.dtack_oe && st.bout.berr_oe))
    else $error("acknowledge and bus error driven together");
  chk_dtack_hold: assert property (st.bout.dtack_oe && ds != 2'h0 |=> st.bout.dtack_oe)
    else $error("acknowledge dropped while a data strobe is held");
  chk_dtack_release: assert property ($fell(st.bout.dtack_oe) |-> $past(ds) == 2'h0)
    else $error("acknowledge released before strobes");
  chk_write_ack: assert property ($rose(st.bout.dtack_oe) && st.wr
    |-> $past(st.st == S_PUSH && buf_in_ready))
    else $error("write acknowledged before the word was buffered");
  chk_read_stable: assert property ($rose(st.bout.dtack_oe) && !st.wr
    |-> $past(st.bout.data_oe) && $stable(st.bout.data))
    else $error("read acknowledged before data stood one cycle");
  chk_data_free: assert property ($fell(st.bout.data_oe)
    |-> $past(ds) == 2'h0 && !st.bout.dtack_oe)
    else $error("read data released out of order");
  chk_size_error: assert property (st.st == S_SEL && as_s && ds_ok && lane_bad
    |=> st.bout.berr_oe && !st.bout.dtack_oe ##1 !buf_in_valid)
    else $error("illegal lane pattern not answered by bus error");
  chk_miss_silent: assert property (st.st == S_MISS
    |-> !st.bout.dtack_oe && !st.bout.berr_oe && !st.bout.data_oe)
    else $error("unselected cycle answered");
  chk_blt_span: assert property (buf_in_valid && st.blt |-> !st.over)
    else $error("block beat crossed its span");
  chk_addr_only: assert property (st.st == S_SEL && !as_s
    |=> st.st == S_IDLE && !st.bout.dtack_oe && !buf_in_valid)
    else $error("address-only cycle not dropped");
  chk_short_lanes: assert property (buf_in_valid && st.lword_n
    |-> st.be != 4'h0 && (st.be[3:2] == 2'h0 || st.be[1:0] == 2'h0))
    else $error("short transfer selected lanes of both halves");

  ////////////////////////////////////////////////////////////////////////////////
  // bus error hold, read data source, push origin and block counter
  chk_berr_hold: assert property (st.bout.berr_oe && ds != 2'h0 |=> st.bout.berr_oe)
    else $error("bus error dropped while a data strobe is held");
  chk_read_source: assert property ($rose(st.bout.data_oe)
    |-> $past(st.st) == S_WAIT && $past(rsp.valid) && !$past(rsp.err))
    else $error("read data driven without a local answer");
  chk_push_origin: assert property ($rose(buf_in_valid)
    |-> $past(st.st) == S_SEL && $past(ds_ok) && !$past(lane_bad))
    else $error("request pushed without an accepted beat");
  chk_blt_step: assert property (st.blt && $past(st.st) == S_ACK && st.st == S_SEL
    |-> st.addr == $past(st.addr) + {29'h0, $past(nbytes)})
    else $error("block beat address did not advance by its size");
endmodule : vmes_slave
`default_nettype wire

// [testbench/vmes_master_model.sv]
// Purpose: bus master on the far side of the slave, one transfer per call
// Assumes: the slave answers through flops; lines are sampled at rising edges
// Notes: released lines show inverted values; a silent slave is cut off after lim cycles
`default_nettype none
module vmes_master_model
  import vmes_pkg::*;
(
  input wire logic ref_clk,
  input wire vmes_bus_out_t bus_out,
  output var vmes_bus_in_t bus_in
);
  timeunit 1ns;
  timeprecision 100ps;
  vmes_bus_in_t bi;
  logic drv;
  logic [1:0] ans;
  logic [31:0] rd;
  int wt;
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    bi = '0;
    bi.as_n = 1'b1;
    bi.ds0_n = 1'b1;
    bi.ds1_n = 1'b1;
    bi.write_n = 1'b1;
    bi.lword_n = 1'b1;
    drv = 1'b0;
  end
  // data lines: master, else slave, else floating pattern
  always_comb
  begin
    bus_in = bi;
    if (!drv)
      bus_in.data = bus_out.data_oe ? bus_out.data : ~bi.data;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // ans: 0 none, 1 acknowledge, 2 bus error, 3 answer dropped or held too long
  task automatic cycle(input logic [5:0] am, input logic [31:0] a, input logic wr,
    input logic lw, input logic [1:0] ds, input logic [31:0] wd, input logic keep);
    int lim;
    int i;
    lim = (ds == 2'b00) ? 8 : 100;
    if (bi.as_n)
    begin
      bi.addr = a;
      bi.am = am;
      @(posedge ref_clk);
      #1;
      bi.as_n = 1'b0;
    end
    bi.lword_n = lw;
    bi.write_n = ~wr;
    bi.data = wd;
    drv = wr;
    @(posedge ref_clk);
    #1;
    bi.ds1_n = ~ds[1];
    bi.ds0_n = ~ds[0];
    ans = 2'd0;
    for (wt = 0; wt < lim && ans == 2'd0; wt++)
    begin
      @(posedge ref_clk);
      rd = bus_in.data;
      ans = bus_out.dtack_oe ? 2'd1 : (bus_out.berr_oe ? 2'd2 : 2'd0);
    end
    i = $urandom % 3;
    repeat (i)
    begin
      @(posedge ref_clk);
      if (ans != 2'd0 && !(bus_out.dtack_oe || bus_out.berr_oe))
        ans = 2'd3;
    end
    #1;
    bi.ds1_n = 1'b1;
    bi.ds0_n = 1'b1;
    drv = 1'b0;
    if (!keep)
    begin
      bi.as_n = 1'b1;
      bi.addr = ~bi.addr;
      bi.am = ~bi.am;
    end
    for (i = 0; i < 20 && (bus_out.dtack_oe || bus_out.berr_oe); i++)
      @(posedge ref_clk);
    if (bus_out.dtack_oe || bus_out.berr_oe)
      ans = 2'd3;
    @(posedge ref_clk);
    #1;
  endtask : cycle
endmodule : vmes_master_model
`default_nettype wire

// [testbench/vmes_slave_tb_top.sv]
// Purpose: self-checking bench of the bus slave
// Assumes: master model drives the bus side, the bench plays the local side
// Notes: expected local requests wait in a queue until the monitor sees them
`default_nettype none
module vmes_slave_tb_top
  import vmes_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk;
  logic rst_n;
  logic priv_only;
  logic req_valid;
  logic req_ready;
  logic stall;
  logic rsp_err;
  vmes_bus_in_t bus_in;
  vmes_bus_out_t bus_out;
  vmes_req_t req;
  vmes_rsp_t rsp;
  vmes_req_t exq[$];
  vmes_req_t ev;
  logic [31:0] ra;
  logic [31:0] a;
  int err_count;
  int compares;
  logic [5:0] am_tab [14] = '{6'h3F, 6'h3E, 6'h3D, 6'h3B, 6'h3A, 6'h39, 6'h2D, 6'h29,
    6'h0F, 6'h0E, 6'h0D, 6'h0B, 6'h0A, 6'h09};
  vmes_slave uut (.ref_clk(ref_clk), .rst_n(rst_n), .bus_in(bus_in), .bus_out(bus_out),
    .priv_only(priv_only), .req(req), .req_valid(req_valid), .req_ready(req_ready), .rsp(rsp));
  vmes_master_model mm (.ref_clk(ref_clk), .bus_out(bus_out), .bus_in(bus_in));
  ////////////////////////////////////////////////////////////////////////////////
  // {error, be}: be[k] is byte k, byte 0 on the top lane
  function automatic logic [4:0] lanes(input logic lw, input logic a1, input logic [1:0] ds);
    case ({lw, a1, ds})
      4'b1011: return 5'h03;
      4'b1010: return 5'h01;
      4'b1001: return 5'h02;
      4'b1111: return 5'h0C;
      4'b1110: return 5'h04;
      4'b1101: return 5'h08;
      4'b0011: return 5'h0F;
      4'b0010: return 5'h07;
      4'b0001: return 5'h0E;
      4'b0111: return 5'h06;
      default: return 5'h10;
    endcase
  endfunction : lanes
  function automatic logic [31:0] to_word(input logic lw, input logic a1, input logic [31:0] d);
    if (!lw)
      return d;
    return a1 ? {16'h0000, d[15:0]} : {d[15:0], 16'h0000};
  endfunction : to_word
  function automatic logic [31:0] msk(input logic [3:0] be);
    return {{8{be[0]}}, {8{be[1]}}, {8{be[2]}}, {8{be[3]}}};
  endfunction : msk
  function automatic logic [31:0] rdw(input logic [31:0] wa);
    return {wa[15:0] ^ 16'hA5C3, wa[15:0]};
  endfunction : rdw
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    if (err_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  // one bus transfer; ea is the expected answer code of the master model
  task automatic xfer(input logic [5:0] am, input logic [31:0] ta, input logic wr,
    input logic lw, input logic [1:0] ds, input logic keep, input logic [1:0] ea);
    logic [4:0] l;
    logic [31:0] wd;
    vmes_req_t e;
    l = lanes(lw, ta[1], ds);
    wd = $urandom;
    e.write = wr;
    e.am = am;
    e.addr = {ta[31:2], 2'b00};
    e.be = l[3:0];
    e.data = to_word(lw, ta[1], wd);
    if (ea == 2'd1 || (rsp_err && !wr))
      exq.push_back(e);
    mm.cycle(am, ta, wr, lw, ds, wd, keep);
    check("bus answer", {30'h0, mm.ans}, {30'h0, ea});
    check("answer levels", {30'h0, bus_out.dtack_n, bus_out.berr_n}, 32'h0);
    if (ea == 2'd1 && !wr)
      check("read data", to_word(lw, ta[1], mm.rd) & msk(l[3:0]), rdw(e.addr) & msk(l[3:0]));
  endtask : xfer
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    req_ready = 1'b0;
    forever
    begin
      @(posedge ref_clk);
      #1;
      req_ready = !stall && ($urandom % 4 != 0);
    end
  end
  // local side answers reads after a random delay
  initial
  begin
    rsp = '0;
    forever
    begin
      @(posedge ref_clk);
      if (rst_n && req_valid && req_ready && !req.write)
      begin
        ra = req.addr;
        repeat ($urandom % 3) @(posedge ref_clk);
        #1;
        rsp = {1'b1, rsp_err, rdw(ra)};
        @(posedge ref_clk);
        #1;
        rsp = '0;
      end
    end
  end
  always @(posedge ref_clk)
    if (rst_n && req_valid && req_ready)
    begin
      if (exq.size() == 0)
        check("unexpected request", 32'h1, 32'h0);
      else
      begin
        ev = exq.pop_front();
        check("request address", req.addr, ev.addr);
        check("request modifier", {26'h0, req.am}, {26'h0, ev.am});
        check("request direction", {31'h0, req.write}, {31'h0, ev.write});
        check("request lanes", {28'h0, req.be}, {28'h0, ev.be});
        if (ev.write)
          check("request data", req.data & msk(ev.be), ev.data & msk(ev.be));
      end
    end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    priv_only = 1'b0;
    stall = 1'b0;
    rsp_err = 1'b0;
    void'($urandom(32'h74947B53));
    repeat (10) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    for (int po = 0; po < 2; po++)
      for (int i = 0; i < 14; i++)
      begin
        priv_only = po[0];
        a = $urandom & 32'h00000FFC;
        xfer(am_tab[i], a, 1'($urandom % 2), 1'b0, 2'b11, 1'b0, {1'b0, !po[0] || am_tab[i][2]});
      end
    priv_only = 1'b0;
    for (int p = 1; p < 16; p++)
      for (int w = 0; w < 2; w++)
        if (p[1:0] != 2'b00)
        begin
          a = $urandom & 32'h00000FFC;
          a[1] = p[2];
          xfer(6'h39, a, w[0], p[3], p[1:0], 1'b0, lanes(p[3], p[2], p[1:0]) > 5'h0F ? 2'd2 : 2'd1);
        end
    xfer(6'h3C, 32'h00000100, 1'b1, 1'b0, 2'b11, 1'b0, 2'd0);
    xfer(6'h39, 32'h00F00000, 1'b1, 1'b0, 2'b11, 1'b0, 2'd0);
    xfer(6'h29, 32'h0000F000, 1'b0, 1'b0, 2'b11, 1'b0, 2'd0);
    xfer(6'h39, 32'h00000200, 1'b0, 1'b0, 2'b00, 1'b0, 2'd0);
    xfer(6'h39, 32'h00000300, 1'b0, 1'b0, 2'b11, 1'b1, 2'd1);
    xfer(6'h39, 32'h00000300, 1'b1, 1'b0, 2'b11, 1'b0, 2'd1);
    xfer(6'h3B, 32'h000000F8, 1'b1, 1'b0, 2'b11, 1'b1, 2'd1);
    xfer(6'h3B, 32'h000000FC, 1'b1, 1'b0, 2'b11, 1'b1, 2'd1);
    xfer(6'h3B, 32'h00000100, 1'b1, 1'b0, 2'b11, 1'b0, 2'd2);
    rsp_err = 1'b1;
    xfer(6'h0D, 32'h00000400, 1'b0, 1'b0, 2'b11, 1'b0, 2'd2);
    rsp_err = 1'b0;
    stall = 1'b1;
    xfer(6'h0D, 32'h00000500, 1'b1, 1'b0, 2'b11, 1'b0, 2'd1);
    xfer(6'h0D, 32'h00000504, 1'b1, 1'b0, 2'b11, 1'b0, 2'd1);
    fork
      begin
        repeat (40) @(posedge ref_clk);
        #1;
        stall = 1'b0;
      end
    join_none
    xfer(6'h0D, 32'h00000508, 1'b1, 1'b0, 2'b11, 1'b0, 2'd1);
    check("stalled acknowledge", {31'h0, mm.wt > 30}, 32'h1);
    repeat (20) @(posedge ref_clk);
    check("pending requests", exq.size(), 32'h0);
    tally_and_finish();
  end
endmodule : vmes_slave_tb_top
`default_nettype wire
